// file: src/cma_pkg.sv
// constants, types and the core state record for the cpu address unit
// assumes a single 100 MHz clock shared by every user of these types
package cma_pkg;

   // data space map
   localparam logic [15:0] IO_BASE    = 16'h0020;
   localparam logic [15:0] SRAM_BASE  = 16'h0060;
   localparam logic [15:0] DATA_END   = 16'h00e0;
   // internal i/o locations and bit-access limit
   localparam logic [5:0]  IO_FLAGS   = 6'h3f;
   localparam logic [5:0]  IO_STACK   = 6'h3d;
   localparam logic [5:0]  IO_BIT_LIM = 6'h20;
   // pointer pairs, low byte then high byte
   localparam logic [4:0]  PTR_A_LO   = 5'h1a;
   localparam logic [4:0]  PTR_B_LO   = 5'h1c;
   localparam logic [4:0]  PTR_C_LO   = 5'h1e;
   localparam logic [4:0]  PTR_C_HI   = 5'h1f;
   // status flag positions
   localparam int F_GIE   = 7;
   localparam int F_COPY  = 6;
   localparam int F_HALF  = 5;
   localparam int F_SIGN  = 4;
   localparam int F_OVF   = 3;
   localparam int F_NEG   = 2;
   localparam int F_ZERO  = 1;
   localparam int F_CARRY = 0;
   // reset values and program counter steps
   localparam logic [7:0]  FLAGS_RST  = 8'h00;
   localparam logic [7:0]  STACK_RST  = 8'h00;
   localparam logic [9:0]  PC_ONE     = 10'h001;
   localparam logic [9:0]  PC_TWO     = 10'h002;

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ACC = 2'b10} cma_state_t;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_ALU = 4'h1, OP_IORD = 4'h2, OP_IOWR = 4'h3,
      OP_BSET = 4'h4, OP_BCLR = 4'h5, OP_SKS = 4'h6, OP_SKC = 4'h7,
      OP_LOAD = 4'h8, OP_STORE = 4'h9, OP_CONST = 4'ha, OP_PJMP = 4'hb,
      OP_RJMP = 4'hc, OP_IRET = 4'hd
   } cma_op_t;

   typedef enum logic [2:0] {
      AM_DIRECT = 3'h0, AM_DISP = 3'h1, AM_IND = 3'h2, AM_PREDEC = 3'h3, AM_POSTINC = 3'h4
   } cma_amode_t;

   typedef enum logic [1:0] {PS_A = 2'h0, PS_B = 2'h1, PS_C = 2'h2} cma_ptr_t;

   typedef struct packed {
      cma_state_t      st;
      logic [9:0]      pc;
      logic [31:0][7:0] rf;
      logic [7:0]      flg;
      logic [7:0]      stk;
      logic [15:0]     addr;
      cma_op_t         op;
      logic [4:0]      rd;
      logic [2:0]      bsel;
      logic [7:0]      wd;
      logic [15:0]     fw;
   } cma_core_t;

endpackage

// file: src/cma_addr_unit.sv
// address generation, data-space decode and program counter of the cpu
// assumes decoded commands, i/o registers and sram on the same clock
// Notes on behaviour
// R1: ten-bit program counter over 1024 sixteen-bit words; one or two words per instruction.
// R2: data decoder spans 224 locations in total.
// R3: first 96 go to registers and i/o, next 128 to sram.
// R4: registers 0x00-0x1f, i/o n at n+0x20, sram 0x60-0xdf.
// R5: registers 26 to 31 form the three sixteen-bit pointers.
// R6: two-register operation reads source and destination, writes destination.
// R7: direct i/o location comes from a six-bit instruction field.
// R8: direct data uses the sixteen-bit second instruction word as address.
// R9: displacement mode adds unsigned six-bit offset to pointer b or c; the code also adds it to pointer a.
// R10: plain indirect uses the pointer value unchanged.
// R11: pre-decrement lowers the pointer, stores it, uses the lowered value.
// R12: post-increment uses the old value, then stores the raised value.
// R13: constant load byte address: upper bits pick word, bit zero picks byte.
// R14: pointer jump and call load the counter from pointer c.
// R15: relative jump and call go to counter plus offset plus one.
// R16: runs straight from the system clock, no division.
// R17: next fetch overlaps execution; single-cycle commands sustain one per clock.
// R18: register alu operation completes in one clock.
// R19: sram access takes two clocks.
// R20: i/o read and write move a byte between register and i/o location.
// R21: bit set, clear and skip tests only for i/o locations below 32.
// R22: software writes reserved bits as zero and never writes reserved i/o.
// R23: status flags at i/o 0x3f, eight read/write bits, reset zero; bit 4 is set to bit 2 xor bit 3 every clock, so writes to it are lost.
// R24: taking an interrupt clears global enable; interrupt return sets it.
// R25: sign flag always equals negative xor overflow.
`timescale 1ns/10ps
module cma_addr_unit
   import cma_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // decoded command
   input  wire logic        cmdValid,
   input  wire cma_op_t     cmdOp,
   input  wire cma_amode_t  cmdMode,
   input  wire cma_ptr_t    cmdPtr,
   input  wire logic [4:0]  cmdDst,
   input  wire logic [4:0]  cmdSrc,
   input  wire logic [5:0]  cmdIo,
   input  wire logic [2:0]  cmdBit,
   input  wire logic [5:0]  cmdDisp,
   input  wire logic [11:0] cmdRel,
   input  wire logic [15:0] cmdWord2,
   input  wire logic [9:0]  retCounter,
   input  wire logic        intTake,
   output logic             cmdReady,
   // program memory
   output logic [9:0]       progAddr,
   input  wire logic [15:0] progData,
   output logic [15:0]      fetchWord,
   // peripheral i/o bus
   output logic [5:0]       ioAddr,
   output logic             ioRd,
   output logic             ioWr,
   output logic [7:0]       ioWdata,
   input  wire logic [7:0]  ioRdata,
   // data sram
   output logic [6:0]       sramAddr,
   output logic             sramRd,
   output logic             sramWr,
   output logic [7:0]       sramWdata,
   input  wire logic [7:0]  sramRdata,
   // visible state
   output logic [9:0]       progCounter,
   output logic [7:0]       statusFlags,
   output logic [7:0]       stackTop
);

   cma_core_t   core_reg;
   cma_core_t   core_next;
   logic        accept;
   logic        acc;
   logic [4:0]  ptrIdx;
   logic [4:0]  ptrHi;
   logic [15:0] ptrVal;
   logic [15:0] ptrC;
   logic        inReg;
   logic        inIo;
   logic        inSram;
   logic [5:0]  ioIdx;
   logic        ioInt;
   logic        isRd;
   logic        isWr;
   logic [7:0]  rb;
   logic [7:0]  wb;
   logic [7:0]  mask;
   logic [7:0]  opA;
   logic [7:0]  opB;
   logic [8:0]  sum;
   logic [7:0]  res;

   // handshake and pointer selection
   assign cmdReady = (core_reg.st == ST_IDLE);
   assign accept   = cmdValid && cmdReady;
   assign acc      = (core_reg.st == ST_ACC);
   assign ptrIdx   = (cmdPtr == PS_A) ? PTR_A_LO : (cmdPtr == PS_B) ? PTR_B_LO : PTR_C_LO; // [R5]
   assign ptrHi    = ptrIdx + 5'h01;
   assign ptrVal   = {core_reg.rf[ptrHi], core_reg.rf[ptrIdx]};
   assign ptrC     = {core_reg.rf[PTR_C_HI], core_reg.rf[PTR_C_LO]};

   // data-space decode of the latched address
   assign inReg  = (core_reg.addr < IO_BASE);                            // [R4]
   assign inIo   = !inReg && (core_reg.addr < SRAM_BASE);                // [R3]
   assign inSram = (core_reg.addr >= SRAM_BASE) && (core_reg.addr < DATA_END); // [R2]
   assign ioIdx  = 6'(core_reg.addr - IO_BASE);
   assign ioInt  = inIo && (ioIdx == IO_FLAGS || ioIdx == IO_STACK);
   assign isRd   = core_reg.op inside {OP_LOAD, OP_IORD, OP_BSET, OP_BCLR, OP_SKS, OP_SKC};
   assign isWr   = core_reg.op inside {OP_STORE, OP_IOWR, OP_BSET, OP_BCLR};

   // bus strobes in the second access cycle
   assign ioAddr    = ioIdx;
   assign ioRd      = acc && inIo && !ioInt && isRd;  // [R20]
   assign ioWr      = acc && inIo && !ioInt && isWr;  // [R20]
   assign sramAddr  = 7'(core_reg.addr - SRAM_BASE);
   assign sramRd    = acc && inSram && isRd;          // [R19]
   assign sramWr    = acc && inSram && isWr;          // [R19]
   assign mask      = 8'h01 << core_reg.bsel;
   assign ioWdata   = wb;
   assign sramWdata = wb;
   assign progAddr  = (acc && core_reg.op == OP_CONST) ? core_reg.addr[10:1] : core_reg.pc; // [R13]
   assign fetchWord   = core_reg.fw;
   assign progCounter = core_reg.pc;
   assign statusFlags = core_reg.flg;
   assign stackTop    = core_reg.stk;

   // read byte from the decoded region, write byte for stores and bit ops
   always_comb begin
      rb = 8'h00;
      if (inReg) begin
         rb = core_reg.rf[core_reg.addr[4:0]];
      end else if (ioInt) begin
         rb = (ioIdx == IO_FLAGS) ? core_reg.flg : core_reg.stk;
      end else if (inIo) begin
         rb = ioRdata;
      end else if (inSram) begin
         rb = sramRdata;
      end
      case (core_reg.op)
         OP_BSET: wb = rb | mask;   // [R21]
         OP_BCLR: wb = rb & ~mask;  // [R21]
         default: wb = core_reg.wd;
      endcase
   end

   // two-register adder operands
   assign opA = core_reg.rf[cmdDst];
   assign opB = core_reg.rf[cmdSrc];
   assign sum = {1'b0, opA} + {1'b0, opB};
   assign res = sum[7:0];

   // next-state of the whole core
   always_comb begin
      core_next = core_reg;
      case (core_reg.st)
         ST_IDLE: begin
            if (accept) begin
               core_next.pc = core_reg.pc + PC_ONE;       // [R1] [R17]
               core_next.fw = progData;                   // [R17]
               core_next.op = cmdOp;
               core_next.rd = cmdDst;
               core_next.bsel = cmdBit;
               core_next.wd = core_reg.rf[cmdSrc];
               case (cmdOp)
                  OP_ALU: begin
                     core_next.rf[cmdDst] = res;          // [R6] [R18]
                     core_next.flg[F_CARRY] = sum[8];
                     core_next.flg[F_ZERO] = (res == 8'h00);
                     core_next.flg[F_NEG] = res[7];
                     core_next.flg[F_OVF] = (opA[7] == opB[7]) && (res[7] != opA[7]);
                     core_next.flg[F_HALF] = (opA[3] & opB[3]) | (opB[3] & ~res[3]) | (~res[3] & opA[3]);
                  end
                  OP_IORD, OP_IOWR: begin
                     core_next.addr = {10'h000, cmdIo} + IO_BASE; // [R7] [R4]
                     core_next.st = ST_ACC;
                  end
                  OP_BSET, OP_BCLR, OP_SKS, OP_SKC: begin
                     if (cmdIo < IO_BIT_LIM) begin        // [R21]
                        core_next.addr = {10'h000, cmdIo} + IO_BASE;
                        core_next.st = ST_ACC;
                     end
                  end
                  OP_LOAD, OP_STORE: begin
                     core_next.st = ST_ACC;
                     case (cmdMode)
                        AM_DIRECT: begin
                           core_next.addr = cmdWord2;     // [R8]
                           core_next.pc = core_reg.pc + PC_TWO;
                        end
                        AM_DISP: core_next.addr = ptrVal + {10'h000, cmdDisp}; // [R9]
                        AM_PREDEC: begin
                           core_next.addr = ptrVal - 16'h0001;   // [R11]
                           {core_next.rf[ptrHi], core_next.rf[ptrIdx]} = ptrVal - 16'h0001;
                        end
                        AM_POSTINC: begin
                           core_next.addr = ptrVal;              // [R12]
                           {core_next.rf[ptrHi], core_next.rf[ptrIdx]} = ptrVal + 16'h0001;
                        end
                        default: core_next.addr = ptrVal;        // [R10]
                     endcase
                  end
                  OP_CONST: begin
                     core_next.addr = ptrC;               // [R13]
                     core_next.st = ST_ACC;
                  end
                  OP_PJMP: core_next.pc = ptrC[9:0];      // [R14]
                  OP_RJMP: core_next.pc = core_reg.pc + cmdRel[9:0] + PC_ONE; // [R15]
                  OP_IRET: begin
                     core_next.pc = retCounter;
                     core_next.flg[F_GIE] = 1'b1;         // [R24]
                  end
                  default: ;
               endcase
            end
         end
         ST_ACC: begin
            core_next.st = ST_IDLE;                       // [R19]
            case (core_reg.op)
               OP_LOAD, OP_IORD: core_next.rf[core_reg.rd] = rb; // [R20]
               OP_CONST: core_next.rf[core_reg.rd] = core_reg.addr[0] ? progData[15:8] : progData[7:0]; // [R13]
               OP_SKS: if (rb[core_reg.bsel]) core_next.pc = core_reg.pc + PC_ONE;  // [R21]
               OP_SKC: if (!rb[core_reg.bsel]) core_next.pc = core_reg.pc + PC_ONE; // [R21]
               default: ;
            endcase
            if (isWr && inReg) core_next.rf[core_reg.addr[4:0]] = wb;
            if (isWr && ioInt && ioIdx == IO_FLAGS) core_next.flg = wb; // [R23]
            if (isWr && ioInt && ioIdx == IO_STACK) core_next.stk = wb;
         end
         default: core_next.st = ST_IDLE;
      endcase
      core_next.flg[F_SIGN] = core_next.flg[F_NEG] ^ core_next.flg[F_OVF]; // [R25]
      if (intTake) core_next.flg[F_GIE] = 1'b0;          // [R24]
   end

   // state register, clocked straight from the system clock
   always_ff @(posedge clk or posedge rst) begin          // [R16]
      if (rst) begin
         core_reg     <= '0;
         core_reg.st  <= ST_IDLE;
         core_reg.flg <= FLAGS_RST;                      // [R23]
         core_reg.stk <= STACK_RST;
      end else begin
         core_reg <= core_next;
      end
   end

   // checks
   a_sram_twocyc: assert property (@(posedge clk) disable iff (rst) // [R19]
      acc |=> cmdReady && !sramRd && !sramWr) else $error("access lasted more than two cycles");
   a_sign_flag: assert property (@(posedge clk) disable iff (rst) // [R25]
      statusFlags[F_SIGN] == (statusFlags[F_NEG] ^ statusFlags[F_OVF])) else $error("sign flag not n xor v");
   a_rel_jump: assert property (@(posedge clk) disable iff (rst) // [R15]
      accept && cmdOp == OP_RJMP |=> progCounter == $past(progCounter) + $past(cmdRel[9:0]) + PC_ONE)
      else $error("relative jump target wrong");
   a_ptr_jump: assert property (@(posedge clk) disable iff (rst) // [R14]
      accept && cmdOp == OP_PJMP |=> progCounter == $past(ptrC[9:0])) else $error("pointer jump target wrong");
   a_post_inc: assert property (@(posedge clk) disable iff (rst) // [R12]
      accept && cmdOp == OP_LOAD && cmdMode == AM_POSTINC |=> core_reg.addr == $past(ptrVal))
      else $error("post-increment address not old pointer");
   a_pre_dec: assert property (@(posedge clk) disable iff (rst) // [R11]
      accept && cmdOp == OP_STORE && cmdMode == AM_PREDEC |=> core_reg.addr == $past(ptrVal) - 16'h0001)
      else $error("pre-decrement address wrong");
   a_int_clear: assert property (@(posedge clk) disable iff (rst) // [R24]
      intTake |=> !statusFlags[F_GIE]) else $error("global enable not cleared");
   a_alu_single: assert property (@(posedge clk) disable iff (rst) // [R18]
      accept && cmdOp == OP_ALU |=> cmdReady && core_reg.rf[$past(cmdDst)] == $past(res))
      else $error("alu result not written in one cycle");
   a_seq_fetch: assert property (@(posedge clk) disable iff (rst) // [R17]
      accept && cmdOp == OP_NOP |=> cmdReady && progCounter == $past(progCounter) + PC_ONE)
      else $error("sequential fetch did not advance");
   a_bit_limit: assert property (@(posedge clk) disable iff (rst) // [R21]
      accept && cmdOp inside {OP_BSET, OP_BCLR} && cmdIo >= IO_BIT_LIM |=> cmdReady)
      else $error("bit op above limit was executed");

   // addressing-mode and program-flow checks, one cycle after the take edge
   a_direct_addr: assert property (@(posedge clk) disable iff (rst) // [R8]
      accept && cmdOp inside {OP_LOAD, OP_STORE} && cmdMode == AM_DIRECT
      |=> core_reg.addr == $past(cmdWord2) && progCounter == $past(progCounter) + PC_TWO)
      else $error("direct address or counter step wrong");
   a_disp_addr: assert property (@(posedge clk) disable iff (rst) // [R9]
      accept && cmdOp inside {OP_LOAD, OP_STORE} && cmdMode == AM_DISP
      |=> core_reg.addr == $past(ptrVal) + {10'h000, $past(cmdDisp)})
      else $error("displacement address wrong");
   a_plain_ind: assert property (@(posedge clk) disable iff (rst) // [R10]
      accept && cmdOp inside {OP_LOAD, OP_STORE} && cmdMode == AM_IND
      |=> core_reg.addr == $past(ptrVal))
      else $error("plain indirect address wrong");
   a_pre_update: assert property (@(posedge clk) disable iff (rst) // [R11]
      accept && cmdOp inside {OP_LOAD, OP_STORE} && cmdMode == AM_PREDEC
      |=> {core_reg.rf[$past(ptrHi)], core_reg.rf[$past(ptrIdx)]} == $past(ptrVal) - 16'h0001)
      else $error("pre-decrement pointer not stored");
   a_post_update: assert property (@(posedge clk) disable iff (rst) // [R12]
      accept && cmdOp inside {OP_LOAD, OP_STORE} && cmdMode == AM_POSTINC
      |=> {core_reg.rf[$past(ptrHi)], core_reg.rf[$past(ptrIdx)]} == $past(ptrVal) + 16'h0001)
      else $error("post-increment pointer not raised");
   a_io_direct: assert property (@(posedge clk) disable iff (rst) // [R7]
      accept && cmdOp inside {OP_IORD, OP_IOWR}
      |=> acc && ioAddr == $past(cmdIo))
      else $error("i/o location not from command field");
   a_const_addr: assert property (@(posedge clk) disable iff (rst) // [R13]
      accept && cmdOp == OP_CONST
      |=> progAddr == $past(ptrC[10:1]))
      else $error("constant word address wrong");
   a_iret_gie: assert property (@(posedge clk) disable iff (rst) // [R24]
      accept && cmdOp == OP_IRET && !intTake
      |=> statusFlags[F_GIE] && progCounter == $past(retCounter))
      else $error("interrupt return did not restore");

endmodule // cma_addr_unit

// file: verif/cma_io_model.sv
// peripheral register model on the i/o bus of the cpu address unit
// assumes one-cycle strobes and read data wanted in the strobe cycle
`timescale 1ns/10ps
module cma_io_model
   import cma_pkg::*;
(
   // clock
   input  wire logic       clk,
   // i/o bus
   input  wire logic [5:0] ioAddr,
   input  wire logic       ioRd,
   input  wire logic       ioWr,
   input  wire logic [7:0] ioWdata,
   output logic      [7:0] ioRdata
);
   logic [7:0] mem [64];
   logic [7:0] fill = 8'h3c;
   // data only while the read strobe stands, else a changing filler
   assign ioRdata = ioRd ? mem[ioAddr] : fill;
   // writes land on the access edge
   always @(posedge clk) begin
      fill <= ~fill;
      if (ioWr)
         mem[ioAddr] <= ioWdata;
   end
   initial foreach (mem[i]) mem[i] = 8'h00;
endmodule // cma_io_model

// file: verif/tb_top.sv
// self-checking bench for the cpu address unit, random and corner commands
// assumes the i/o model on the bus; sram and program words modelled here
`timescale 1ns/10ps
module tb_top
   import cma_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, cmdValid = 1'b0, intTake = 1'b0;
   cma_op_t     cmdOp = OP_NOP;
   cma_amode_t  cmdMode = AM_IND;
   cma_ptr_t    cmdPtr = PS_A;
   logic [4:0]  cmdDst = 5'h00, cmdSrc = 5'h00;
   logic [5:0]  cmdIo = 6'h00, cmdDisp = 6'h00, dispV = 6'h00, ioAddr;
   logic [2:0]  cmdBit = 3'h0, bitV = 3'h0;
   logic [11:0] cmdRel = 12'h000, relV = 12'h000;
   logic [15:0] cmdWord2 = 16'h0000, w2V = 16'h0000, progData, fetchWord;
   logic [9:0]  retCounter = 10'h000, progAddr, progCounter, p;
   logic        cmdReady, ioRd, ioWr, sramRd, sramWr;
   logic [6:0]  sramAddr;
   logic [7:0]  ioWdata, ioRdata, sramWdata, sramRdata, statusFlags, stackTop;
   logic [7:0]  fill = 8'h5a;
   logic [7:0]  sram [128];
   logic [7:0]  shadow [32];
   logic [5:0]  ioT [4] = '{6'h1b, 6'h18, 6'h0f, 6'h07};
   logic [11:0] relT [4] = '{12'h7ff, 12'h800, 12'hfff, 12'h000};
   logic [15:0] dirT [8] = '{16'h0001, 16'h0020, 16'h005c, 16'h0060, 16'h00df, 16'h00e0, 16'h0100, 16'h0070};
   int          errors = 0, check_count = 0;

   initial forever #5 clk = ~clk;
   // program words follow the address, sram answers only while selected
   assign progData  = pword(progAddr);
   assign sramRdata = sramRd ? sram[sramAddr] : fill;
   always @(posedge clk) begin
      fill <= ~fill;
      if (sramWr)
         sram[sramAddr] <= sramWdata;
   end

   cma_addr_unit dut_u (
      .clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdMode(cmdMode), .cmdPtr(cmdPtr),
      .cmdDst(cmdDst), .cmdSrc(cmdSrc), .cmdIo(cmdIo), .cmdBit(cmdBit), .cmdDisp(cmdDisp),
      .cmdRel(cmdRel), .cmdWord2(cmdWord2), .retCounter(retCounter), .intTake(intTake),
      .cmdReady(cmdReady), .progAddr(progAddr), .progData(progData), .fetchWord(fetchWord),
      .ioAddr(ioAddr), .ioRd(ioRd), .ioWr(ioWr), .ioWdata(ioWdata), .ioRdata(ioRdata),
      .sramAddr(sramAddr), .sramRd(sramRd), .sramWr(sramWr), .sramWdata(sramWdata),
      .sramRdata(sramRdata), .progCounter(progCounter), .statusFlags(statusFlags), .stackTop(stackTop));
   cma_io_model io_u (.clk(clk), .ioAddr(ioAddr), .ioRd(ioRd), .ioWr(ioWr), .ioWdata(ioWdata), .ioRdata(ioRdata));

   function automatic logic [15:0] pword(input logic [9:0] a);
      return {a[5:0] ^ 6'h2a, a};
   endfunction
   // flags after an 8-bit add; top two bits untouched
   function automatic logic [7:0] addFlags(input logic [7:0] f, input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      logic       vf;
      s = {1'b0, a} + {1'b0, b};
      vf = (a[7] == b[7]) && (s[7] != a[7]);
      return {f[7:6], ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f, s[7] ^ vf, vf, s[7], s[7:0] == 8'h00, s[8]};
   endfunction

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one command, ends at the middle of the cycle after the take edge
   task automatic cmd(input cma_op_t o, input cma_amode_t m, input cma_ptr_t pt, input logic [4:0] d,
                      input logic [4:0] s, input logic [5:0] io);
      @(posedge clk);
      cmdOp <= o;
      cmdMode <= m;
      cmdPtr <= pt;
      cmdDst <= d;
      cmdSrc <= s;
      cmdIo <= io;
      cmdBit <= bitV;
      cmdDisp <= dispV;
      cmdRel <= relV;
      cmdWord2 <= w2V;
      retCounter <= 10'($urandom);
      cmdValid <= 1'b1;
      @(posedge clk);
      cmdValid <= 1'b0;
      @(negedge clk);
   endtask
   // model word changes only after the previous access cycle was taken in
   task automatic ld(input logic [4:0] r, input logic [7:0] v);
      @(negedge clk);
      io_u.mem[6'h05] = v;
      shadow[r] = v;
      cmd(OP_IORD, AM_IND, PS_A, r, 5'h00, 6'h05);
   endtask
   task automatic getr(input logic [4:0] r, input logic [7:0] e);
      cmd(OP_IOWR, AM_IND, PS_A, 5'h00, r, 6'h1b);
      chk({ioWr, ioAddr, ioWdata}, {1'b1, 6'h1b, e});
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude();
   end

   initial begin
      logic [7:0]  a, b, v, e;
      logic [15:0] z, ea, nz;
      logic [4:0]  r;
      cma_op_t     op;
      cma_amode_t  md;
      cma_ptr_t    pt;
      void'($urandom(37233));
      foreach (shadow[i]) shadow[i] = 8'h00;
      foreach (sram[i]) sram[i] = 8'($urandom);
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({progCounter, cmdReady}, {10'h000, 1'b1});
      chk({statusFlags, stackTop}, {FLAGS_RST, STACK_RST});
      // register add, corners then random
      for (int k = 0; k < 6; k++) begin
         a = k == 0 ? 8'h7f : k == 1 ? 8'h80 : 8'($urandom);
         b = k == 0 ? 8'h01 : k == 1 ? 8'h80 : 8'($urandom);
         ld(5'h01, a);
         ld(5'h02, b);
         p = progCounter;
         v = statusFlags;
         cmd(OP_ALU, AM_IND, PS_A, 5'h01, 5'h02, 6'h00);
         chk({cmdReady, progCounter}, {1'b1, p + PC_ONE});
         chk(fetchWord, pword(p));
         chk(statusFlags, addFlags(v, a, b));
         shadow[1] = a + b;
         getr(5'h01, a + b);
      end
      // flags and stack sit inside, never on the bus
      v = 8'($urandom);
      ld(5'h03, v);
      cmd(OP_IOWR, AM_IND, PS_A, 5'h00, 5'h03, IO_FLAGS);
      chk(ioWr, 1'b0);
      @(negedge clk);
      chk(statusFlags, {v[7:5], v[2] ^ v[3], v[3:0]});
      cmd(OP_IOWR, AM_IND, PS_A, 5'h00, 5'h03, IO_STACK);
      @(negedge clk);
      chk(stackTop, v);
      @(posedge clk);
      intTake <= 1'b1;
      @(posedge clk);
      intTake <= 1'b0;
      @(negedge clk);
      chk(statusFlags[F_GIE], 1'b0);
      // return from interrupt sets the enable again after the clear
      cmd(OP_IRET, AM_IND, PS_A, 5'h00, 5'h00, 6'h00);
      chk({statusFlags[F_GIE], progCounter}, {1'b1, retCounter});
      // direct address over the whole data map
      foreach (dirT[k]) begin
         ea = dirT[k];
         v = 8'($urandom);
         io_u.mem[6'(ea - IO_BASE)] = v;
         sram[7'(ea - SRAM_BASE)] = v;
         e = ea < IO_BASE ? shadow[ea[4:0]] : ea < DATA_END ? v : 8'h00;
         w2V = ea;
         p = progCounter;
         cmd(OP_LOAD, AM_DIRECT, PS_A, 5'h04, 5'h00, 6'h00);
         chk(progCounter, 10'(p + PC_TWO));
         chk({ioRd, sramRd}, {ea >= IO_BASE && ea < SRAM_BASE, ea >= SRAM_BASE && ea < DATA_END});
         if (ioRd)
            chk(ioAddr, 6'(ea - IO_BASE));
         if (sramRd)
            chk(sramAddr, 7'(ea - SRAM_BASE));
         shadow[4] = e;
         getr(5'h04, e);
      end
      // pointer modes; loads and stores alternate
      ld(5'h05, 8'($urandom));
      for (int k = 0; k < 12; k++) begin
         pt = cma_ptr_t'(k % 3);
         md = cma_amode_t'(1 + k / 3);
         if (md == AM_DISP && pt == PS_A)
            pt = PS_C;
         z = 16'h0061 + 16'($urandom_range(0, 62));
         dispV = 6'($urandom);
         r = PTR_A_LO + {pt, 1'b0};
         ld(r, z[7:0]);
         ld(r + 5'h01, z[15:8]);
         ea = md == AM_DISP ? z + dispV : md == AM_PREDEC ? z - 16'h0001 : z;
         nz = md == AM_POSTINC ? z + 16'h0001 : md == AM_PREDEC ? ea : z;
         cmd(k % 2 ? OP_STORE : OP_LOAD, md, pt, 5'h04, 5'h05, 6'h00);
         chk({cmdReady, sramAddr}, {1'b0, 7'(ea - SRAM_BASE)});
         chk({sramRd, sramWr}, {k % 2 == 0, k % 2 == 1});
         if (k % 2)
            chk(sramWdata, shadow[5]);
         getr(r, nz[7:0]);
         getr(r + 5'h01, nz[15:8]);
      end
      // constant bytes from program words, then jump through the same pointer
      for (int k = 0; k < 4; k++) begin
         z = 16'($urandom);
         z[0] = k[0];
         ld(PTR_C_LO, z[7:0]);
         ld(PTR_C_HI, z[15:8]);
         cmd(OP_CONST, AM_IND, PS_A, 5'h06, 5'h00, 6'h00);
         chk(progAddr, z[10:1]);
         ea = pword(z[10:1]);
         getr(5'h06, z[0] ? ea[15:8] : ea[7:0]);
         cmd(OP_PJMP, AM_IND, PS_A, 5'h00, 5'h00, 6'h00);
         chk(progCounter, z[9:0]);
      end
      foreach (relT[k]) begin
         relV = relT[k];
         p = progCounter;
         cmd(OP_RJMP, AM_IND, PS_A, 5'h00, 5'h00, 6'h00);
         chk(progCounter, 10'(p + relV[9:0] + PC_ONE));
         p = progCounter;
         cmd(OP_NOP, AM_IND, PS_A, 5'h00, 5'h00, 6'h00);
         chk(progCounter, 10'(p + PC_ONE));
      end
      // bit set, clear and skips; the last two go above the bit window
      for (int k = 0; k < 10; k++) begin
         op = cma_op_t'(OP_BSET + k % 4);
         v = 8'($urandom);
         bitV = 3'($urandom);
         io_u.mem[ioT[k % 4]] = v;
         p = progCounter;
         cmd(op, AM_IND, PS_A, 5'h00, 5'h00, k > 7 ? 6'h2e : ioT[k % 4]);
         e = op == OP_BSET ? v | (8'h01 << bitV) : v & ~(8'h01 << bitV);
         if (k > 7)
            chk({ioRd, ioWr, progCounter}, {2'b00, p + PC_ONE});
         else if (op < OP_SKS)
            chk({ioWr, ioAddr, ioWdata}, {1'b1, ioT[k % 4], e});
         else begin
            @(negedge clk);
            chk(progCounter, 10'(p + PC_ONE + 10'(v[bitV] == (op == OP_SKS))));
         end
      end
      conclude();
   end
endmodule // tb_top
